// ===== include/icdiag_consts.vh
// Constants for the instruction cache diagnostic access block
`ifndef ICDIAG_CONSTS_VH
`define ICDIAG_CONSTS_VH
`define ICDIAG_ADDR_DATA_LOW 12'h07c9
`define ICDIAG_ADDR_CHECK 12'h07ca
`define ICDIAG_ADDR_TRIGGER 12'h07cb
`define ICDIAG_ADDR_DATA_HIGH 12'h07cc
`define ICDIAG_RESET_WORD 32'h0000_0000
`define ICDIAG_ARRAY_DATA 1'b0
`define ICDIAG_ARRAY_TAG 1'b1
`define ICDIAG_TAG_LSB 11
`define ICDIAG_LRU_LSB 4
`define ICDIAG_LRU_MSB 6
`define ICDIAG_VALID_BIT 0
`define ICDIAG_GO_BIT 0
`define ICDIAG_INDEX_W 14
`define ICDIAG_SET_W 8
`define ICDIAG_TAG_W 21
`define ICDIAG_DATA_ECC_W 7
`define ICDIAG_TAG_ECC_W 5
`define ICDIAG_CHUNK_W 64
`define ICDIAG_DEPTH 1024
`define ICDIAG_ADDR_W 10
`define ICDIAG_TAG_ENTRY_W 27
`define ICDIAG_DATA_ENTRY_W 71
`endif

// ===== verilog/icdiag_ram.v
// Single-port memory with registered read data
module icdiag_ram #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_sys, // Clock
  input wire we, // Write strobe
  input wire re, // Read strobe
  input wire [AW-1:0] addr, // Word address
  input wire [WIDTH-1:0] wdata, // Write data
  output reg [WIDTH-1:0] rdata // Registered read data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  always @(posedge clk_sys)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    if (re)
    begin
      rdata <= mem[addr];
    end
  end
endmodule // icdiag_ram

// ===== verilog/icdiag_lru.v
// Per-set pseudo-LRU storage shared by all ways
module icdiag_lru (
  input wire clk_sys, // Clock
  input wire rst, // Synchronous reset
  input wire four_way, // Four-way build
  input wire we, // Write strobe
  input wire [7:0] set, // Set number
  input wire [2:0] wdata, // New LRU bits
  output reg [2:0] rdata // Registered LRU bits
);
  reg [2:0] lru [0:255];
  integer i;
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (i = 0; i < 256; i = i + 1)
        lru[i] <= 3'h0;
      rdata <= 3'h0;
    end
    else
    begin
      if (we)
      begin
        lru[set] <= four_way ? wdata : {2'h0, wdata[0]};
      end
      rdata <= lru[set];
    end
  end
endmodule // icdiag_lru

// ===== verilog/icdiag_top.v
// Instruction cache diagnostic access registers and array port
// How it works
// - Registers answer only in debug mode
// - Low register layout follows selected array
// - Select zero data array, one tag array
// - Low register carries chunk bytes three to zero
// - High register carries chunk bytes seven to four
// - Tag right-justified, unused tag bits read zero
// - LRU bits shared by all ways
// - Four-way LRU tree bit meanings
// - Two-way uses lowest LRU bit only
// - Bit zero holds line valid flag
// - Parity build: four half-word even parities
// - Parity build tag: one even parity
// - ECC build data: seven-bit code
// - ECC build tag: five-bit code
// - Hardware makes and checks codes normally
// - Diagnostic writes store check bits unchanged
// - Trigger read loads array into registers
// - Writing one stores registers into array
// - Trigger reads zero, only one writes
`include "icdiag_consts.vh"
module icdiag_top #(
  parameter USE_ECC = 0, // Check layout, fixed at build
  parameter FOUR_WAY = 1, // Associativity, fixed at build
  parameter TAG_USED = 21 // Tag bits used for this cache size
) (
  input wire clk_sys, // Clock
  input wire rst, // Synchronous reset, active high
  input wire csr_rd, // CSR read strobe
  input wire csr_wr, // CSR write strobe
  input wire [11:0] csr_addr, // CSR address
  input wire [31:0] csr_wdata, // CSR write data
  input wire debug_mode, // Core is in debug mode
  input wire sel_array, // Array select from location register
  input wire [1:0] sel_way, // Way select
  input wire [13:0] sel_index, // Index select
  input wire fill_en, // Normal fill strobe
  input wire fill_tag, // Fill targets tag array
  input wire [63:0] fill_data, // Fill chunk or tag word
  input wire fetch_en, // Normal fetch read strobe
  output reg [31:0] csr_rdata, // CSR read data
  output reg csr_hit, // Access taken by this block
  output reg csr_illegal, // Illegal instruction pulse
  output reg [63:0] fetch_data, // Fetched chunk
  output reg fetch_err // Check error on fetch
);
  function [3:0] half_par;
    input [63:0] d;
    begin
      half_par = {^d[63:48], ^d[47:32], ^d[31:16], ^d[15:0]};
    end
  endfunction
  function [6:0] data_ecc;
    input [63:0] d;
    integer k;
    reg [6:0] e;
    begin
      e = 7'h00;
      for (k = 0; k < 64; k = k + 1)
        e = e ^ (k[6:0] + 7'h01);
      for (k = 0; k < 64; k = k + 1)
        if (d[k])
          e = e ^ (k[6:0] + 7'h01);
      data_ecc = e ^ {6'h00, ^d};
    end
  endfunction
  function [4:0] tag_ecc;
    input [20:0] t;
    integer k;
    reg [4:0] e;
    begin
      e = {4'h0, ^t};
      for (k = 0; k < 21; k = k + 1)
        if (t[k])
          e = e ^ (k[4:0] + 5'h01);
      tag_ecc = e;
    end
  endfunction
  function [6:0] make_check;
    input tag_sel;
    input [63:0] d;
    begin
      if (tag_sel)
        make_check = USE_ECC ? {2'h0, tag_ecc(d[31:11])} : {6'h00, ^d[31:11]};
      else
        make_check = USE_ECC ? data_ecc(d) : {3'h0, half_par(d)};
    end
  endfunction
  function [31:0] check_view;
    input tag_sel;
    input [6:0] c;
    begin
      if (tag_sel)
        check_view = USE_ECC ? {27'h0, c[4:0]} : {31'h0, c[0]};
      else
        check_view = USE_ECC ? {25'h0, c[6:0]} : {28'h0, c[3:0]};
    end
  endfunction
  reg [31:0] data_low;
  reg [31:0] data_high;
  reg [6:0] check;
  reg rd_pend;
  reg rd_tag;
  reg fetch_pend;
  reg fetch_tag;
  reg [2:0] lru_w;
  wire acc;
  wire [20:0] tag_mask;
  wire trig_rd;
  wire trig_wr;
  wire [9:0] array_addr;
  wire [7:0] set_addr;
  wire diag_data_we;
  wire diag_tag_we;
  wire fill_data_we;
  wire fill_tag_we;
  wire [70:0] data_wentry;
  wire [26:0] tag_wentry;
  wire [70:0] data_rentry;
  wire [26:0] tag_rentry;
  wire [2:0] lru_rd;
  wire [20:0] fill_tagv;
  wire [6:0] fill_chk;
  wire [31:0] low_view;
  wire [31:0] wr_ck_view;
  wire [31:0] data_ck_mask;
  wire [31:0] tag_ck_mask;
  // Check bits kept at the width of the selected layout
  assign wr_ck_view = check_view(sel_array, csr_wdata[6:0]);
  assign data_ck_mask = check_view(1'b0, 7'h7f);
  assign tag_ck_mask = check_view(1'b1, 7'h7f);
  assign acc = (csr_addr == `ICDIAG_ADDR_DATA_LOW) || (csr_addr == `ICDIAG_ADDR_CHECK) ||
    (csr_addr == `ICDIAG_ADDR_TRIGGER) || (csr_addr == `ICDIAG_ADDR_DATA_HIGH);
  assign tag_mask = {21{1'b1}} >> (`ICDIAG_TAG_W - TAG_USED);
  assign trig_rd = debug_mode && csr_rd && (csr_addr == `ICDIAG_ADDR_TRIGGER);
  assign trig_wr = debug_mode && csr_wr && (csr_addr == `ICDIAG_ADDR_TRIGGER) &&
    csr_wdata[`ICDIAG_GO_BIT];
  // Data and tag rows both ignore the chunk bits of the index
  assign array_addr = {sel_way, sel_index[10:3]};
  assign set_addr = sel_index[10:3];
  assign diag_data_we = trig_wr && (sel_array == `ICDIAG_ARRAY_DATA);
  assign diag_tag_we = trig_wr && (sel_array == `ICDIAG_ARRAY_TAG);
  assign fill_data_we = fill_en && !fill_tag && !trig_wr;
  assign fill_tag_we = fill_en && fill_tag && !trig_wr;
  assign fill_tagv = fill_data[31:11] & tag_mask;
  assign fill_chk = make_check(fill_tag, fill_data);
  // Stored check bits are software's when written diagnostically
  assign data_wentry = diag_data_we ? {check, data_high, data_low} :
    {fill_chk, fill_data};
  assign tag_wentry = diag_tag_we ? {check[4:0], data_low[31:11] & tag_mask, data_low[0]} :
    {fill_chk[4:0], fill_tagv, fill_data[0]};
  icdiag_ram #(
    .WIDTH(`ICDIAG_DATA_ENTRY_W),
    .DEPTH(`ICDIAG_DEPTH),
    .AW(`ICDIAG_ADDR_W)
  ) u_data (
    .clk_sys(clk_sys),
    .we(diag_data_we || fill_data_we),
    .re(1'b1),
    .addr(array_addr),
    .wdata(data_wentry),
    .rdata(data_rentry)
  );
  icdiag_ram #(
    .WIDTH(`ICDIAG_TAG_ENTRY_W),
    .DEPTH(`ICDIAG_DEPTH),
    .AW(`ICDIAG_ADDR_W)
  ) u_tag (
    .clk_sys(clk_sys),
    .we(diag_tag_we || fill_tag_we),
    .re(1'b1),
    .addr(array_addr),
    .wdata(tag_wentry),
    .rdata(tag_rentry)
  );
  always @*
  begin
    lru_w = data_low[`ICDIAG_LRU_MSB:`ICDIAG_LRU_LSB];
  end
  icdiag_lru u_lru (
    .clk_sys(clk_sys),
    .rst(rst),
    .four_way(FOUR_WAY != 0),
    .we(diag_tag_we),
    .set(set_addr),
    .wdata(lru_w),
    .rdata(lru_rd)
  );
  // Tag view of the low register
  assign low_view = (sel_array == `ICDIAG_ARRAY_TAG) ?
    {data_low[31:11] & tag_mask, 4'h0, data_low[6:4], 3'h0, data_low[0]} : data_low;
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      data_low <= `ICDIAG_RESET_WORD;
      data_high <= `ICDIAG_RESET_WORD;
      check <= 7'h00;
      rd_pend <= 1'b0;
      rd_tag <= 1'b0;
      fetch_pend <= 1'b0;
      fetch_tag <= 1'b0;
      csr_rdata <= `ICDIAG_RESET_WORD;
      csr_hit <= 1'b0;
      csr_illegal <= 1'b0;
      fetch_data <= 64'h0000_0000_0000_0000;
      fetch_err <= 1'b0;
    end
    else
    begin
      csr_hit <= acc && (csr_rd || csr_wr) && debug_mode;
      csr_illegal <= acc && (csr_rd || csr_wr) && !debug_mode;
      rd_pend <= trig_rd;
      rd_tag <= sel_array;
      fetch_pend <= fetch_en;
      fetch_tag <= fill_tag;
      csr_rdata <= `ICDIAG_RESET_WORD;
      if (debug_mode && csr_rd)
      begin
        case (csr_addr)
          `ICDIAG_ADDR_DATA_LOW: csr_rdata <= low_view;
          `ICDIAG_ADDR_DATA_HIGH: csr_rdata <= data_high;
          `ICDIAG_ADDR_CHECK: csr_rdata <= check_view(sel_array, check);
          `ICDIAG_ADDR_TRIGGER: csr_rdata <= `ICDIAG_RESET_WORD;
          default: csr_rdata <= `ICDIAG_RESET_WORD;
        endcase
      end
      if (debug_mode && csr_wr)
      begin
        case (csr_addr)
          `ICDIAG_ADDR_DATA_LOW: data_low <= csr_wdata;
          `ICDIAG_ADDR_DATA_HIGH: data_high <= csr_wdata;
          `ICDIAG_ADDR_CHECK: check <= wr_ck_view[6:0];
          default: check <= check;
        endcase
      end
      if (rd_pend)
      begin
        if (rd_tag)
        begin
          data_low <= {tag_rentry[21:1], 4'h0, lru_rd, 3'h0, tag_rentry[0]};
          data_high <= `ICDIAG_RESET_WORD;
          check <= {2'h0, tag_rentry[26:22]} & tag_ck_mask[6:0];
        end
        else
        begin
          data_low <= data_rentry[31:0];
          data_high <= data_rentry[63:32];
          check <= data_rentry[70:64] & data_ck_mask[6:0];
        end
      end
      if (fetch_pend)
      begin
        if (fetch_tag)
        begin
          fetch_data <= {32'h0, tag_rentry[21:1], 10'h0, tag_rentry[0]};
          fetch_err <= make_check(1'b1, {32'h0, tag_rentry[21:1], 11'h0}) !=
            (({2'h0, tag_rentry[26:22]}) & tag_ck_mask[6:0]);
        end
        else
        begin
          fetch_data <= data_rentry[63:0];
          fetch_err <= make_check(1'b0, data_rentry[63:0]) !=
            (data_rentry[70:64] & data_ck_mask[6:0]);
        end
      end
      else
      begin
        fetch_err <= 1'b0;
      end
    end
  end
endmodule // icdiag_top

// ===== verif/icdiag_props.sv
// Assertion checker for the diagnostic access block
module icdiag_props #(
  parameter USE_ECC = 0
) (
  input wire clk_sys, // Clock
  input wire rst, // Reset
  input wire csr_rd, // Read
  input wire csr_wr, // Write
  input wire [11:0] csr_addr, // Address
  input wire debug_mode, // Debug
  input wire sel_array, // Array
  input wire [31:0] csr_rdata, // Data
  input wire csr_hit, // Taken
  input wire csr_illegal // Refused
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire mine = csr_addr >= 12'h7c9 && csr_addr <= 12'h7cc;
  wire req = (csr_rd || csr_wr) && mine;
  sequence s_dbg; req && debug_mode; endsequence
  sequence s_usr; req && !debug_mode; endsequence
  sequence s_rd(a); csr_rd && debug_mode && csr_addr == a; endsequence
  property p_hit; s_dbg |=> csr_hit && !csr_illegal; endproperty
  a_hit: assert property (p_hit) else $error("hit missing");
  property p_ill; s_usr |=> csr_illegal && !csr_hit && csr_rdata == 0; endproperty
  a_ill: assert property (p_ill) else $error("illegal missing");
  property p_quiet; !(csr_rd || csr_wr) |=> !csr_hit && !csr_illegal && csr_rdata == 0; endproperty
  a_quiet: assert property (p_quiet) else $error("idle output");
  property p_cause; csr_hit |-> $past(debug_mode) && $past(req); endproperty
  a_cause: assert property (p_cause) else $error("hit without cause");
  property p_go; s_rd(12'h7cb) |=> csr_rdata == 0; endproperty
  a_go: assert property (p_go) else $error("trigger nonzero");
  property p_ckd; s_rd(12'h7ca) ##0 !sel_array |=> (csr_rdata >> (USE_ECC ? 7 : 4)) == 0; endproperty
  a_ckd: assert property (p_ckd) else $error("data check reserved");
  property p_ckt; s_rd(12'h7ca) ##0 sel_array |=> (csr_rdata >> (USE_ECC ? 5 : 1)) == 0; endproperty
  a_ckt: assert property (p_ckt) else $error("tag check reserved");
  property p_tagz; s_rd(12'h7c9) ##0 sel_array |=> csr_rdata[10:7] == 0 && csr_rdata[3:1] == 0;
  endproperty
  a_tagz: assert property (p_tagz) else $error("tag unused bits");
endmodule // icdiag_props
bind icdiag_top icdiag_props #(.USE_ECC(USE_ECC)) u_props (.clk_sys, .rst, .csr_rd, .csr_wr,
  .csr_addr, .debug_mode, .sel_array, .csr_rdata, .csr_hit, .csr_illegal);

// ===== verif/icdiag_host.sv
// CSR access path model driving the diagnostic registers
module icdiag_host (
  input wire clk_sys, // Clock
  input wire [31:0] csr_rdata, // Read data
  output logic csr_rd, // Read strobe
  output logic csr_wr, // Write strobe
  output logic [11:0] csr_addr, // Address
  output logic [31:0] csr_wdata // Write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {csr_rd, csr_wr, csr_addr, csr_wdata} = '0;
  // One-cycle access; released address and data show inverted values
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(negedge clk_sys);
    {csr_rd, csr_wr, csr_addr, csr_wdata} = {!w, w, a, d};
    @(negedge clk_sys);
    q = csr_rdata;
    {csr_rd, csr_wr, csr_addr, csr_wdata} = {2'b00, ~a, ~d};
  endtask
endmodule // icdiag_host

// ===== verif/testbench.sv
// Self-checking testbench for the diagnostic access block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] lo_a = 12'h7c9;
  localparam logic [11:0] ck_a = 12'h7ca;
  localparam logic [11:0] go_a = 12'h7cb;
  localparam logic [11:0] hi_a = 12'h7cc;
  localparam logic [31:0] tmask = 32'hffff_ff8f;
  logic clk_sys, rst, csr_rd, csr_wr, debug_mode, sel_array, fill_en, fill_tag, fetch_en;
  logic csr_hit, csr_illegal, fetch_err;
  logic [1:0] sel_way;
  logic [13:0] sel_index;
  logic [11:0] csr_addr;
  logic [31:0] csr_wdata, csr_rdata, q, lo, hi;
  logic [31:0] csr_rdata2;
  logic [63:0] fill_data, fetch_data;
  logic [3:0] ck;
  int mismatches, n_compared;
  icdiag_top #(.TAG_USED(13)) uut (.clk_sys, .rst, .csr_rd, .csr_wr, .csr_addr, .csr_wdata,
    .debug_mode, .sel_array, .sel_way, .sel_index, .fill_en, .fill_tag, .fill_data,
    .fetch_en, .csr_rdata, .csr_hit, .csr_illegal, .fetch_data, .fetch_err);
  // Second build: check code layout and two-way LRU
  icdiag_top #(.USE_ECC(1), .FOUR_WAY(0), .TAG_USED(13)) uut2 (.clk_sys, .rst, .csr_rd,
    .csr_wr, .csr_addr, .csr_wdata, .debug_mode, .sel_array, .sel_way, .sel_index, .fill_en,
    .fill_tag, .fill_data, .fetch_en, .csr_rdata(csr_rdata2), .csr_hit(), .csr_illegal(),
    .fetch_data(), .fetch_err());
  icdiag_host u_host (.clk_sys, .csr_rdata, .csr_rd, .csr_wr, .csr_addr, .csr_wdata);
  initial
  begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    n_compared++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    u_host.acc(1'b0, a, 32'h0, q);
    chk($sformatf("csr %h", a), e & m, q & m);
  endtask
  task automatic go_rd;
    rd(go_a, 32'h0);
    @(negedge clk_sys);
  endtask
  task automatic t_reset;
    rd(lo_a, 32'h0);
    rd(hi_a, 32'h0);
    rd(ck_a, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_data;
    {sel_array, sel_way, sel_index} = {1'b0, 2'd2, 14'h0128};
    lo = 32'hc3a5_1e0f;
    hi = 32'h7b21_9d46;
    ck = {^hi[31:16], ^hi[15:0], ^lo[31:16], ^lo[15:0]} ^ 4'h1;
    wr(lo_a, lo);
    wr(hi_a, hi);
    wr(ck_a, {28'hfff_ffff, ck});
    rd(ck_a, {28'h0, ck});
    chk("ecc data check", {60'h7, ck}, {32'h0, csr_rdata2});
    wr(go_a, 32'h1);
    wr(lo_a, ~lo);
    wr(go_a, 32'h0);
    go_rd;
    rd(lo_a, lo);
    rd(hi_a, hi);
    rd(ck_a, {28'h0, ck});
    @(negedge clk_sys) fetch_en = 1;
    @(negedge clk_sys) fetch_en = 0;
    @(negedge clk_sys);
    chk("fetch data", {hi, lo}, fetch_data);
    chk("fetch err", 64'h1, {63'h0, fetch_err});
    $display("t_data done");
  endtask
  task automatic t_tag;
    {sel_array, sel_way} = {1'b1, 2'd1};
    lo = {8'h00, 13'h1a5c, 4'hf, 3'b101, 3'b111, 1'b1};
    wr(lo_a, lo);
    wr(ck_a, {31'h0, ^lo[31:11]});
    wr(go_a, 32'h1);
    sel_way = 2'd3;
    go_rd;
    rd(lo_a, 32'h50, 32'h70);
    chk("two-way lru", 64'h10, {32'h0, csr_rdata2 & 32'h70});
    sel_way = 2'd1;
    go_rd;
    rd(lo_a, lo & 32'hffff_f871);
    rd(ck_a, {31'h0, ^lo[31:11]});
    chk("ecc tag check", {63'h0, ^lo[31:11]}, {32'h0, csr_rdata2});
    $display("t_tag done");
  endtask
  task automatic t_fill;
    sel_way = 2'd0;
    @(negedge clk_sys);
    {fill_en, fill_tag, fill_data} = {2'b11, 64'h0000_0000_0059_b801};
    @(negedge clk_sys);
    {fill_en, fill_data} = {1'b0, ~fill_data};
    go_rd;
    rd(lo_a, 32'h0059_b801, tmask);
    rd(ck_a, {31'h0, ^(32'h0059_b801 >> 11)});
    $display("t_fill done");
  endtask
  task automatic t_mode;
    debug_mode = 0;
    wr(lo_a, 32'h0);
    chk("illegal", 64'h1, {63'h0, csr_illegal});
    debug_mode = 1;
    rd(lo_a, 32'h0059_b801, tmask);
    chk("hit", 64'h1, {63'h0, csr_hit});
    $display("t_mode done");
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    {rst, debug_mode} = 2'b11;
    {sel_array, sel_way, sel_index, fill_en, fill_tag, fetch_en, fill_data} = '0;
    repeat (6) @(negedge clk_sys);
    rst = 0;
    t_reset;
    t_data;
    t_tag;
    t_fill;
    t_mode;
    stop_test;
  end
  initial
  begin
    repeat (2000) @(posedge clk_sys);
    mismatches++;
    stop_test;
  end
endmodule // testbench
